// ===== src/lsag_defines.svh
// Purpose: register offsets, field positions and reset values of the line status
//          and acquisition gate block
// Assumes: 8-bit APB byte address, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef LSAG_DEFINES_SVH
`define LSAG_DEFINES_SVH

// register byte offsets
`define LSAG_OFF_GP_LVL     8'h00
`define LSAG_OFF_SPARE_LVL  8'h04
`define LSAG_OFF_CC1_LVL    8'h08
`define LSAG_OFF_CC2_LVL    8'h0c
`define LSAG_OFF_CC3_LVL    8'h10
`define LSAG_OFF_ALL_LVL    8'h14
`define LSAG_OFF_GP_POL     8'h18
`define LSAG_OFF_SPARE_POL  8'h1c
`define LSAG_OFF_CC1_POL    8'h20
`define LSAG_OFF_CC2_POL    8'h24
`define LSAG_OFF_CC3_POL    8'h28
`define LSAG_OFF_LINE_SEL   8'h2c
`define LSAG_OFF_SEL_STAT   8'h30
`define LSAG_OFF_ACQ_CTRL   8'h34
`define LSAG_OFF_BURST_LEN  8'h38
`define LSAG_OFF_ACQ_STAT   8'h3c

// field positions
`define LSAG_SEL_LVL_BIT    0
`define LSAG_SEL_POL_BIT    1
`define LSAG_CTRL_EN_BIT    0
`define LSAG_CTRL_SW_ACQ    1
`define LSAG_CTRL_SW_FRM    2
`define LSAG_STAT_WACQ_BIT  0
`define LSAG_STAT_WFRM_BIT  1

// reset values
`define LSAG_RST_SEL        3'h0
`define LSAG_RST_ACQ_EN     1'b0
`define LSAG_RST_BURST      16'h0001

// line count and synchroniser depth
`define LSAG_NUM_LINES      5
`define LSAG_SYNC_STAGES    2

`endif

// ===== src/lsag_pkg.sv
// Purpose: types shared by the line status and acquisition gate block
// Assumes: constants live in lsag_defines.svh
// Notes:   one-hot acquisition status codes
package lsag_pkg;

  // acquisition status, one-hot
  typedef enum logic [1:0]
  {
    LSAG_WAIT_ACQ   = 2'b01,
    LSAG_WAIT_FRAME = 2'b10
  } lsag_acq_st_t;

  // line picker codes
  typedef enum logic [2:0]
  {
    LSAG_LINE_GP    = 3'h0,
    LSAG_LINE_SPARE = 3'h1,
    LSAG_LINE_CC1   = 3'h2,
    LSAG_LINE_CC2   = 3'h3,
    LSAG_LINE_CC3   = 3'h4
  } lsag_line_t;

  // whole state of the top module
  typedef struct packed
  {
    lsag_acq_st_t fsm;
    logic [1:0]   trg_prev;
    logic [2:0]   sel;
    logic         acq_en;
    logic [15:0]  burst;
    logic [15:0]  cnt;
    logic         frame_go;
    logic [31:0]  rd_data;
    logic         rd_err;
  } lsag_state_t;

endpackage

// ===== src/lsag_sync.sv
// Purpose: two-stage synchroniser for a vector of asynchronous pins
// Assumes: each bit is an independent level
// Notes:   only stage two leaves the module
`timescale 1ns/1ps
module lsag_sync
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins and synchronised copy
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // both stages in one state word
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lsag_sync_st_t;

  lsag_sync_st_t st_ff;   // registered stages
  lsag_sync_st_t nxt_st;  // next stages

  generate
    if (W < 1)
    begin : g_chk
      $error("lsag_sync: width must be at least one");
    end
  endgenerate

  // stage one only feeds stage two, which keeps metastability away from logic
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end

  // constant reset, pins are never loaded under reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign dout = st_ff.s2;

endmodule

// ===== src/lsag_top.sv
// Purpose: line level and polarity readback plus acquisition start gate, APB slave
// Assumes: one clock pclk at 250 MHz, pins asynchronous, zero-wait APB
// Notes:   frame start events pass only while waiting for frame start
//
// Behaviour
// - picked line reads high true, low false
// - general line level reads 1 high, 0 low
// - spare and CC1-CC3 have own level registers
// - 32-bit word holds every line's present level
// - zero bit in word means line low
// - picked line reports its polarity type
// - general line polarity reads 1 positive, 0 negative
// - spare and CC1-CC3 have own polarity registers
// - gate off makes acquisition start internally
// - gate on starts waiting for acquisition start (here only once the running burst count is reached)
// - no frame start while waiting for acquisition
// - acquisition start moves to waiting for frames
// - burst count reached returns to acquisition wait
// - stay waiting until new acquisition start
// - frame starts outside frame wait are dropped
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lsag_defines.svh"
module lsag_top
  import lsag_pkg::*;
#(
  parameter logic [4:0]  LINE_POS  = 5'h1f,          // polarity per line, 1 positive
  parameter logic [15:0] BURST_RST = `LSAG_RST_BURST // burst length after reset
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // i/o line pins: gp, spare, cc1, cc2, cc3
  input  wire logic        gp_line,
  input  wire logic        spare_line,
  input  wire logic [2:0]  cc_line,
  // hardware trigger pins
  input  wire logic        acq_start_pin,
  input  wire logic        frame_start_pin,
  // acquisition outputs
  output logic             frame_go,
  output logic             wait_acq,
  output logic             wait_frame
);

  lsag_state_t st_ff;        // all registered state
  lsag_state_t nxt_st;       // next state
  logic [6:0]  pins_raw;     // pins before synchronising
  logic [6:0]  pins_sync;    // pins after two flops
  logic [4:0]  line_lvl;     // synchronised line levels
  logic        acq_evt;      // acquisition start event, any source
  logic        frame_evt;    // frame start event, any source
  logic        wr_en;        // write taken this edge
  logic        setup_rd;     // read setup phase
  logic        sw_acq;       // software acquisition start
  logic        sw_frm;       // software frame start
  logic [15:0] cnt_inc;      // frame count plus one

  generate
    if (BURST_RST == 16'h0000)
    begin : g_chk
      $error("lsag_top: burst length after reset must be nonzero");
    end
  endgenerate

  // select one bit of a line vector, unused picker codes give zero
  function automatic logic pick(input logic [4:0] v, input logic [2:0] s);
    logic r;
    r = 1'b0;
    if (s < 3'h5)
      r = v[s];
    return r;
  endfunction

  // address is a mapped register
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `LSAG_OFF_ACQ_STAT);
  endfunction

  // read value of a register, zero where unmapped
  function automatic logic [31:0] rd_word(input logic [7:0] a, input logic [4:0] lv,
                                          input lsag_state_t s);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      `LSAG_OFF_GP_LVL:    r[0] = lv[0];
      `LSAG_OFF_SPARE_LVL: r[0] = lv[1];
      `LSAG_OFF_CC1_LVL:   r[0] = lv[2];
      `LSAG_OFF_CC2_LVL:   r[0] = lv[3];
      `LSAG_OFF_CC3_LVL:   r[0] = lv[4];
      `LSAG_OFF_ALL_LVL:   r[4:0] = lv;
      `LSAG_OFF_GP_POL:    r[0] = LINE_POS[0];
      `LSAG_OFF_SPARE_POL: r[0] = LINE_POS[1];
      `LSAG_OFF_CC1_POL:   r[0] = LINE_POS[2];
      `LSAG_OFF_CC2_POL:   r[0] = LINE_POS[3];
      `LSAG_OFF_CC3_POL:   r[0] = LINE_POS[4];
      `LSAG_OFF_LINE_SEL:  r[2:0] = s.sel;
      `LSAG_OFF_SEL_STAT:
      begin
        r[`LSAG_SEL_LVL_BIT] = pick(lv, s.sel);
        r[`LSAG_SEL_POL_BIT] = pick(LINE_POS, s.sel);
      end
      `LSAG_OFF_ACQ_CTRL:  r[`LSAG_CTRL_EN_BIT] = s.acq_en;
      `LSAG_OFF_BURST_LEN: r[15:0] = s.burst;
      `LSAG_OFF_ACQ_STAT:
      begin
        r[`LSAG_STAT_WACQ_BIT] = s.fsm[0];
        r[`LSAG_STAT_WFRM_BIT] = s.fsm[1];
        r[31:16]               = s.cnt;
      end
      default:             r = 32'h0;
    endcase
    return r;
  endfunction

  // lines and trigger pins come from outside the clock domain
  assign pins_raw = {frame_start_pin, acq_start_pin, cc_line, spare_line, gp_line};

  lsag_sync #(.W(7)) u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pins_raw),
    .dout    (pins_sync)
  );

  // bit map of the all-lines word: 0 gp, 1 spare, 2..4 cc1..cc3, rest zero
  assign line_lvl = pins_sync[4:0];

  // bus decode, zero-wait so every access phase is the taking edge
  assign wr_en    = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign sw_acq   = wr_en && (paddr == `LSAG_OFF_ACQ_CTRL) && pwdata[`LSAG_CTRL_SW_ACQ];
  assign sw_frm   = wr_en && (paddr == `LSAG_OFF_ACQ_CTRL) && pwdata[`LSAG_CTRL_SW_FRM];

  // rising pin edges and software writes both count as trigger events
  assign acq_evt   = sw_acq || (pins_sync[5] && !st_ff.trg_prev[0]);
  assign frame_evt = sw_frm || (pins_sync[6] && !st_ff.trg_prev[1]);
  assign cnt_inc   = st_ff.cnt + 16'h0001;

  // next state: registers, read capture and the acquisition gate
  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.trg_prev = pins_sync[6:5];
    nxt_st.frame_go = 1'b0;
    // read data is latched at setup so it comes from a flop in the access phase
    if (setup_rd)
    begin
      nxt_st.rd_data = rd_word(paddr, line_lvl, st_ff);
      nxt_st.rd_err  = !mapped(paddr);
    end
    else if (psel && !penable)
    begin
      nxt_st.rd_data = 32'h0;
      nxt_st.rd_err  = !mapped(paddr);
    end
    // register writes
    if (wr_en)
    begin
      unique case (paddr)
        `LSAG_OFF_LINE_SEL:  nxt_st.sel    = pwdata[2:0];
        `LSAG_OFF_ACQ_CTRL:  nxt_st.acq_en = pwdata[`LSAG_CTRL_EN_BIT];
        `LSAG_OFF_BURST_LEN: nxt_st.burst  = pwdata[15:0];
        default:             nxt_st.sel    = st_ff.sel;
      endcase
    end
    // acquisition gate
    unique case (st_ff.fsm)
      LSAG_WAIT_ACQ:
      begin
        // frame starts here are dropped
        if (acq_evt || !st_ff.acq_en)
        begin
          nxt_st.fsm = LSAG_WAIT_FRAME;
          nxt_st.cnt = 16'h0000;
        end
      end
      LSAG_WAIT_FRAME:
      begin
        if (frame_evt)
        begin
          nxt_st.frame_go = 1'b1;
          nxt_st.cnt      = cnt_inc;
          // a burst length of zero matches only when the count wraps, so the burst ends after 65536 frames
          if (cnt_inc == st_ff.burst)
            nxt_st.fsm = LSAG_WAIT_ACQ;
        end
      end
      default:
      begin
        nxt_st.fsm = LSAG_WAIT_ACQ;
      end
    endcase
  end

  // state register, gate starts in acquisition wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '{fsm: LSAG_WAIT_ACQ, trg_prev: 2'h3, sel: `LSAG_RST_SEL,
                 acq_en: `LSAG_RST_ACQ_EN, burst: BURST_RST, cnt: 16'h0000,
                 frame_go: 1'b0, rd_data: 32'h0, rd_err: 1'b0};
    else
      st_ff <= nxt_st;
  end

  // outputs
  assign prdata     = st_ff.rd_data;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && st_ff.rd_err;
  assign frame_go   = st_ff.frame_go;
  assign wait_acq   = st_ff.fsm[0];
  assign wait_frame = st_ff.fsm[1];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // read setup for a given offset
  sequence s_rd(logic [7:0] off);
    psel && !penable && !pwrite && (paddr == off);
  endsequence

  // gate passes from acquisition wait into frame wait
  sequence s_enter_frame;
    wait_acq ##1 wait_frame;
  endsequence

  property p_sel_lvl;
    s_rd(`LSAG_OFF_SEL_STAT) |=> prdata[0] == pick($past(line_lvl), $past(st_ff.sel));
  endproperty
  a_sel_lvl: assert property (p_sel_lvl) else $error("picked line level wrong");

  property p_gp_lvl;
    s_rd(`LSAG_OFF_GP_LVL) |=> prdata == {31'h0, $past(pins_sync[0])};
  endproperty
  a_gp_lvl: assert property (p_gp_lvl) else $error("general line level wrong");

  property p_cc3_lvl;
    s_rd(`LSAG_OFF_CC3_LVL) |=> prdata == {31'h0, $past(cc_line[2], 3)};
  endproperty
  a_cc3_lvl: assert property (p_cc3_lvl) else $error("cc3 level wrong");

  property p_all_lvl;
    s_rd(`LSAG_OFF_ALL_LVL) |=> prdata == {27'h0, $past(pins_raw[4:0], 3)};
  endproperty
  a_all_lvl: assert property (p_all_lvl) else $error("all-lines word wrong");

  property p_sel_pol;
    s_rd(`LSAG_OFF_SEL_STAT) |=> prdata[1] == pick(LINE_POS, $past(st_ff.sel));
  endproperty
  a_sel_pol: assert property (p_sel_pol) else $error("picked polarity wrong");

  property p_spare_pol;
    s_rd(`LSAG_OFF_SPARE_POL) |=> prdata == {31'h0, LINE_POS[1]};
  endproperty
  a_spare_pol: assert property (p_spare_pol) else $error("spare polarity wrong");

  // the edge that releases reset still loads reset values, so only count cycles seen out of reset
  property p_free_run;
    presetn && wait_acq && !st_ff.acq_en |=> wait_frame;
  endproperty
  a_free_run: assert property (p_free_run) else $error("gate off did not start");

  // a dropped frame leaves the count alone, unless the gate enters a burst and clears it
  property p_drop;
    frame_evt && !wait_frame |=>
      !frame_go && (wait_frame ? (st_ff.cnt == 16'h0000) : $stable(st_ff.cnt));
  endproperty
  a_drop: assert property (p_drop) else $error("frame start taken while waiting");

  property p_acq_go;
    wait_acq && acq_evt |=> wait_frame ##1 (frame_go == $past(frame_evt));
  endproperty
  a_acq_go: assert property (p_acq_go) else $error("acquisition start not taken");

  property p_burst_end;
    wait_frame && frame_evt && (cnt_inc == st_ff.burst) |=> wait_acq && frame_go;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst did not end");

  property p_hold;
    wait_acq && st_ff.acq_en && !acq_evt |=> wait_acq;
  endproperty
  a_hold: assert property (p_hold) else $error("left acquisition wait unprompted");

  property p_cnt_clr;
    s_enter_frame |-> st_ff.cnt == 16'h0000;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("frame count not cleared");

endmodule

// ===== sim/lsag_far_model.sv
// Purpose: far-side model, a frame grabber driving camera lines and trigger pins
// Assumes: pins change just after a rising pclk edge
// Notes:   trigger pins rest low between pulses; pulse width models quick or slow grabbers
`timescale 1ns/1ps
module lsag_far_model
(
  // clock
  input  wire logic       pclk,
  // line pins
  output logic            gp_line,
  output logic            spare_line,
  output logic [2:0]      cc_line,
  // trigger pins
  output logic            acq_start_pin,
  output logic            frame_start_pin
);
  // all pins low at time zero
  initial
  begin
    gp_line = 1'b0;
    spare_line = 1'b0;
    cc_line = 3'h0;
    acq_start_pin = 1'b0;
    frame_start_pin = 1'b0;
  end

  // drive all five lines: bit0 gp, bit1 spare, bits 4:2 cc1..cc3
  task automatic set_lines(input logic [4:0] lv);
    @(posedge pclk);
    gp_line <= lv[0];
    spare_line <= lv[1];
    cc_line <= lv[4:2];
  endtask

  // one trigger pulse; frame high picks the frame pin, else acquisition pin
  task automatic pulse(input logic frame, input int wid);
    @(posedge pclk);
    if (frame)
      frame_start_pin <= 1'b1;
    else
      acq_start_pin <= 1'b1;
    repeat (wid) @(posedge pclk);
    frame_start_pin <= 1'b0;
    acq_start_pin <= 1'b0;
  endtask
endmodule

// ===== sim/lsag_top_test.sv
// Purpose: self-checking bench for line readback and the acquisition gate
// Assumes: zero-wait apb slave, pins seen after sync and edge detect
// Notes:   polarity parameter mixes positive and negative lines on purpose
`timescale 1ns/1ps
module lsag_top_test;
  localparam logic [4:0] POS = 5'h15;   // gp, cc1, cc3 positive; others negative

  // clock, reset and apb
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // pins and gate outputs
  logic        gp_line;
  logic        spare_line;
  logic [2:0]  cc_line;
  logic        acq_start_pin;
  logic        frame_start_pin;
  logic        frame_go;
  logic        wait_acq;
  logic        wait_frame;
  // bench state
  int          err_total;
  int          compares;
  int          nfr;
  int          n0;
  int          i;
  int          k;
  logic [31:0] d;
  logic [4:0]  lv;
  logic [2:0]  sel;

  lsag_top #(.LINE_POS(POS)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gp_line(gp_line), .spare_line(spare_line),
    .cc_line(cc_line), .acq_start_pin(acq_start_pin), .frame_start_pin(frame_start_pin),
    .frame_go(frame_go), .wait_acq(wait_acq), .wait_frame(wait_frame));

  lsag_far_model i_far (.pclk(pclk), .gp_line(gp_line), .spare_line(spare_line),
    .cc_line(cc_line), .acq_start_pin(acq_start_pin), .frame_start_pin(frame_start_pin));

  // free-running clock, 4 ns period
  always #2 pclk = ~pclk;

  // count accepted frame starts, one per pulse
  always @(posedge pclk)
    if (frame_go === 1'b1)
      nfr <= nfr + 1;

  // compare and report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; waits for pready, then releases with one idle edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic xerr, output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait: only the watchdog ends a stuck access
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", {31'h0, pslverr}, {31'h0, xerr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    apb(1'b1, a, wd, 1'b0, x);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // picked line word: bit0 level, bit1 polarity, zero for codes past cc3
  function automatic logic [31:0] exp_pick(input logic [2:0] s, input logic [4:0] v);
    if (s > 3'h4)
      return 32'h0;
    return {30'h0, POS[s], v[s]};
  endfunction

  task automatic give_verdict;
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog, far beyond the several hundred cycles the sequence needs
  initial
  begin
    idle(20000);
    err_total++;
    give_verdict;
  end

  // main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    compares = 0;
    nfr = 0;
    void'($urandom(15));
    idle(20);
    // gate sits in acquisition wait while reset is held
    chk("rst_wacq", {31'h0, wait_acq}, 32'h1);
    chk("rst_wfrm", {31'h0, wait_frame}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h34, 32'h0, 1'b0, d);
    chk("ctrl_rst", d, 32'h0);
    apb(1'b0, 8'h38, 32'h0, 1'b0, d);
    chk("burst_rst", d, 32'h1);
    // line levels and polarity: all-low and all-high corners, then random
    for (i = 0; i < 10; i++)
    begin
      lv = (i < 2) ? {5{i[0]}} : 5'($urandom);
      sel = 3'($urandom_range(7, 0));
      i_far.set_lines(lv);
      wr(8'h2c, {29'h0, sel});
      idle(4);
      for (k = 0; k < 5; k++)
      begin
        apb(1'b0, 8'(k * 4), 32'h0, 1'b0, d);
        chk("line_lvl", d, {31'h0, lv[k]});
        apb(1'b0, 8'(8'h18 + k * 4), 32'h0, 1'b0, d);
        chk("line_pol", d, {31'h0, POS[k]});
      end
      apb(1'b0, 8'h14, 32'h0, 1'b0, d);
      chk("all_lines", d, {27'h0, lv});
      apb(1'b0, 8'h30, 32'h0, 1'b0, d);
      chk("picked", d, exp_pick(sel, lv));
    end
    // read-only write ignored, unmapped places refused
    wr(8'h14, 32'hffffffff);
    apb(1'b0, 8'h14, 32'h0, 1'b0, d);
    chk("ro_word", d, {27'h0, lv});
    apb(1'b0, 8'h40, 32'h0, 1'b1, d);
    chk("unmapped", d, 32'h0);
    apb(1'b1, 8'h41, 32'h0, 1'b1, d);
    // gate on, burst of three, run out the current burst
    wr(8'h38, 32'h3);
    wr(8'h34, 32'h1);
    for (i = 0; i < 4 && wait_acq !== 1'b1; i++)
    begin
      wr(8'h34, 32'h5);
      idle(2);
    end
    chk("in_wacq", {31'h0, wait_acq}, 32'h1);
    n0 = nfr;
    wr(8'h34, 32'h5);
    i_far.pulse(1'b1, 2);
    idle(6);
    chk("drop_frames", 32'(nfr - n0), 32'h0);
    apb(1'b0, 8'h3c, 32'h0, 1'b0, d);
    chk("stay_wacq", d & 32'h3, 32'h1);
    i_far.pulse(1'b0, $urandom_range(3, 1));
    idle(6);
    apb(1'b0, 8'h3c, 32'h0, 1'b0, d);
    chk("hw_acq", d, 32'h2);
    chk("wait_frame", {31'h0, wait_frame}, 32'h1);
    i_far.pulse(1'b1, 1);
    idle(6);
    apb(1'b0, 8'h3c, 32'h0, 1'b0, d);
    chk("one_frame", d, 32'h00010002);
    wr(8'h34, 32'h5);
    wr(8'h34, 32'h5);
    idle(2);
    chk("burst_frames", 32'(nfr - n0), 32'h3);
    apb(1'b0, 8'h3c, 32'h0, 1'b0, d);
    chk("burst_end", d & 32'h3, 32'h1);
    wr(8'h34, 32'h3);
    idle(2);
    apb(1'b0, 8'h3c, 32'h0, 1'b0, d);
    chk("sw_acq", d, 32'h2);
    // gate off: burst ends, acquisition restarts on its own
    wr(8'h34, 32'h0);
    for (i = 0; i < 3; i++)
      wr(8'h34, 32'h4);
    idle(4);
    apb(1'b0, 8'h3c, 32'h0, 1'b0, d);
    chk("auto_acq", d & 32'h3, 32'h2);
    chk("all_frames", 32'(nfr - n0), 32'h6);
    give_verdict;
  end
endmodule
